// ### src/mbag_circ_fix.sv
// circular buffer boundary correction, combinational
`timescale 1ns/100ps
module mbag_circ_fix (
    input wire logic enable,
    input wire logic incr,
    input wire logic [15:0] value,
    input wire logic [15:0] start,
    input wire logic [15:0] stop,
    output logic [15:0] fixed,
    output logic wrapped
);
    logic [15:0] len;

    assign len = 16'(stop - start + 16'h0001);

    // compare past the limit, not just equal, so big steps still wrap
    always_comb
    begin
        fixed = value;
        wrapped = 1'b0;
        if (enable && incr && value > stop)
        begin
            fixed = 16'(value - len);
            wrapped = 1'b1;
        end
        else if (enable && !incr && value < start)
        begin
            fixed = 16'(value + len);
            wrapped = 1'b1;
        end
    end
endmodule

// ### src/mbag_pkg.sv
// shared constants and carrier types for the address generator
package mbag_pkg;

    // ==========================================================
    // widths and encodings
    localparam int MBAG_AW = 16;
    localparam logic [3:0] MBAG_STACK_SEL = 4'hf;
    localparam logic [15:0] MBAG_WORD_STEP = 16'h0002;
    localparam logic [15:0] MBAG_BYTE_STEP = 16'h0001;

    // ==========================================================
    // register map, byte addresses on the bus
    localparam logic [7:0] MBAG_REG_BITREV = 8'h00;
    localparam logic [7:0] MBAG_REG_CIRC_CTRL = 8'h04;
    localparam logic [7:0] MBAG_REG_CIRC_START = 8'h08;
    localparam logic [7:0] MBAG_REG_CIRC_END = 8'h0c;
    localparam logic [7:0] MBAG_REG_STATUS = 8'h10;

    // ==========================================================
    // field positions and reset values
    localparam int MBAG_BITREV_ENABLE_BIT = 15;
    localparam int MBAG_CIRC_EN_BIT = 15;
    localparam int MBAG_BREV_SEL_LSB = 8;
    localparam int MBAG_CIRC_SEL_LSB = 0;
    localparam int MBAG_STAT_BREV_BIT = 16;
    localparam int MBAG_STAT_WRAP_BIT = 17;
    localparam logic [15:0] MBAG_BITREV_RST = 16'h0000;
    localparam logic [15:0] MBAG_CIRC_CTRL_RST = 16'h0f0f;
    localparam logic [15:0] MBAG_CIRC_START_RST = 16'h0000;
    localparam logic [15:0] MBAG_CIRC_END_RST = 16'hffff;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        MBAG_INDIRECT, MBAG_POST_INC, MBAG_POST_DEC, MBAG_PRE_INC, MBAG_PRE_DEC, MBAG_REG_OFFSET
    } mbag_mode_e;

    typedef struct packed {
        logic valid;
        logic [3:0] ptr_sel;
        mbag_mode_e mode;
        logic byte_size;
        logic write;
        logic x_unit;
        logic [15:0] offset;
    } mbag_req_s;

    typedef struct packed {
        logic bitrev_enable;
        logic [14:0] pivot_modifier;
        logic circ_en;
        logic [3:0] circ_sel;
        logic [3:0] bitrev_pointer_select;
        logic [15:0] start;
        logic [15:0] stop;
    } mbag_ctrl_s;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic bitrev;
        logic wrapped;
        logic updated;
    } mbag_ea_s;

endpackage

// ### src/mbag_top.sv
// address generator: pointer file, circular and bit-reversed addressing
// ==========================================================
// Function
// - circular correction may be applied to the address formed from any pointer.
// - the boundary check is above the upper limit when incrementing, below the lower when decrementing.
// - the corrected address is written back to the pointer only for pre- and post-modify modes.
// - register-plus-offset addresses are corrected but leave the pointer untouched.
// - bit-reversal lives only in the X generator and only for data writes.
// - pointer and modifier are both bit-reversed for the add; the stored pointer and the address stay in normal order.
// - bit-reversal needs a non-all-ones pointer select, the enable bit, and pre/post increment.
// - the pivot modifier is a 15-bit field, usually half the buffer size.
// - reversed addresses are word addresses: pivot scaled to bytes, low bit forced to zero.
// - outside pre/post increment word writes, ordinary addresses are produced.
// - while reversing, the pivot replaces the mode's own increment.
// - with both modes on the same pointer, reversal wins for writes.
`timescale 1ns/100ps
module mbag_top #(
    parameter int NPTR = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input mbag_pkg::mbag_req_s req_i,
    input wire logic ptr_wr_en,
    input wire logic [3:0] ptr_wr_idx,
    input wire logic [15:0] ptr_wr_data,
    input wire logic [3:0] ptr_rd_idx,
    output logic [15:0] ptr_rd_data,
    output mbag_pkg::mbag_ea_s ea_o
);
    import mbag_pkg::*;

    // ==========================================================
    // state and wires
    mbag_ctrl_s ctrl;
    logic [15:0] ptr_reg [NPTR];
    mbag_ea_s ea_reg;
    mbag_ea_s ea_next;
    logic [15:0] w;
    logic [15:0] step;
    logic [15:0] delta;
    logic incr;
    logic [15:0] sum;
    logic [15:0] sum_fixed;
    logic sum_wrapped;
    logic circ_hit;
    logic incr_mode;
    logic modify_mode;
    logic brev_on;
    logic [15:0] pivot_bytes;
    logic [15:0] w_rev;
    logic [15:0] pivot_rev;
    logic [15:0] rev_sum;
    logic [15:0] brev_next;
    logic [15:0] ptr_next;
    logic ext_hit;
    logic [17:0] status_reg;

    // ==========================================================
    // control registers
    mbag_wb_regs u_regs (
        .clock(clock),
        .rst(rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .status_i(status_reg),
        .ctrl_o(ctrl)
    );

    // ==========================================================
    // operand selection
    // registers feed the request directly, no forwarding of a fresh write
    assign w = ptr_reg[req_i.ptr_sel];
    assign ptr_rd_data = ptr_reg[ptr_rd_idx];
    assign ext_hit = ptr_wr_en && ptr_wr_idx == req_i.ptr_sel;
    assign step = req_i.byte_size ? MBAG_BYTE_STEP : MBAG_WORD_STEP;

    always_comb
    begin
        delta = 16'h0000;
        incr = 1'b1;
        unique case (req_i.mode)
            MBAG_POST_INC, MBAG_PRE_INC:
                delta = step;
            MBAG_POST_DEC, MBAG_PRE_DEC:
            begin
                delta = 16'(-step);
                incr = 1'b0;
            end
            MBAG_REG_OFFSET:
            begin
                delta = req_i.offset;
                incr = !req_i.offset[15];
            end
            MBAG_INDIRECT:
                delta = 16'h0000;
            default:
                delta = 16'h0000;
        endcase
    end

    assign sum = 16'(w + delta);
    assign incr_mode = req_i.mode == MBAG_PRE_INC || req_i.mode == MBAG_POST_INC;
    assign modify_mode = incr_mode || req_i.mode == MBAG_PRE_DEC
        || req_i.mode == MBAG_POST_DEC;

    // ==========================================================
    // circular correction, any pointer may be the circular one
    assign circ_hit = ctrl.circ_en && ctrl.circ_sel == req_i.ptr_sel;

    mbag_circ_fix u_circ (
        .enable(circ_hit),
        .incr(incr),
        .value(sum),
        .start(ctrl.start),
        .stop(ctrl.stop),
        .fixed(sum_fixed),
        .wrapped(sum_wrapped)
    );

    // ==========================================================
    // bit-reversed modifier
    // stack pointer select of all ones can never reverse
    assign brev_on = req_i.x_unit && req_i.write
        && !req_i.byte_size && incr_mode
        && ctrl.bitrev_enable && ctrl.bitrev_pointer_select != MBAG_STACK_SEL
        && ctrl.bitrev_pointer_select == req_i.ptr_sel;

    assign pivot_bytes = {ctrl.pivot_modifier, 1'b0};

    // reverse-carry add: carries run from msb toward lsb
    for (genvar i = 0; i < MBAG_AW; i++)
    begin : g_rev
        assign w_rev[i] = w[MBAG_AW - 1 - i];
        assign pivot_rev[i] = pivot_bytes[MBAG_AW - 1 - i];
        assign brev_next[i] = (i == 0) ? 1'b0 : rev_sum[MBAG_AW - 1 - i];
    end

    // pointer and modifier are both added in reversed order, the result is unreversed
    assign rev_sum = 16'(w_rev + pivot_rev);

    // ==========================================================
    // address and write-back selection
    assign ptr_next = brev_on ? brev_next : sum_fixed;

    always_comb
    begin
        ea_next.valid = req_i.valid;
        ea_next.bitrev = req_i.valid && brev_on;
        ea_next.wrapped = req_i.valid && !brev_on && circ_hit && sum_wrapped;
        ea_next.updated = req_i.valid && modify_mode;
        ea_next.addr = w;
        if (brev_on)
        begin
            // word-only addressing, low bit never set
            if (req_i.mode == MBAG_PRE_INC)
                ea_next.addr = brev_next;
            else
                ea_next.addr = {w[15:1], 1'b0};
        end
        else
        begin
            unique case (req_i.mode)
                MBAG_PRE_INC, MBAG_PRE_DEC, MBAG_REG_OFFSET:
                    ea_next.addr = sum_fixed;
                MBAG_POST_INC, MBAG_POST_DEC, MBAG_INDIRECT:
                    ea_next.addr = w;
                default:
                    ea_next.addr = w;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ea_reg <= '0;
        else
            ea_reg <= ea_next;
    end

    assign ea_o = ea_reg;

    // ea_reg is refreshed on idle cycles too, so status keeps the last real request
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            status_reg <= 18'h00000;
        else if (ea_next.valid)
            status_reg <= {ea_next.wrapped, ea_next.bitrev, ea_next.addr};
    end

    // ==========================================================
    // pointer file
    // a core load to the same pointer in the same cycle wins
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int k = 0; k < NPTR; k++)
                ptr_reg[k] <= 16'h0000;
        end
        else
        begin
            if (req_i.valid && modify_mode)
                ptr_reg[req_i.ptr_sel] <= ptr_next;
            if (ptr_wr_en)
                ptr_reg[ptr_wr_idx] <= ptr_wr_data;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_offset_req;
        req_i.valid && req_i.mode == MBAG_REG_OFFSET && !ext_hit;
    endsequence

    sequence s_plain_post;
        req_i.valid && req_i.mode == MBAG_POST_INC && !req_i.byte_size
            && !brev_on && !circ_hit && !ext_hit;
    endsequence

    sequence s_brev_req;
        req_i.valid && brev_on && !ext_hit;
    endsequence

    sequence s_circ_last_word;
        req_i.valid && req_i.mode == MBAG_PRE_INC && !req_i.byte_size && !brev_on
            && circ_hit && w == 16'(ctrl.stop - 16'h0001) && ctrl.stop > ctrl.start;
    endsequence

    chk_offset_keeps_ptr: assert property (
        s_offset_req |=> ptr_reg[$past(req_i.ptr_sel)] == $past(w)
            && ea_reg.addr == $past(sum_fixed) && !ea_reg.updated)
        else $error("offset mode changed the pointer");

    chk_post_modify_wb: assert property (
        s_plain_post |=> ea_reg.addr == $past(w)
            && ptr_reg[$past(req_i.ptr_sel)] == 16'($past(w) + 16'h0002))
        else $error("post increment did not write back");

    chk_brev_word_align: assert property (
        ea_reg.valid && ea_reg.bitrev |-> ea_reg.addr[0] == 1'b0)
        else $error("reversed address is odd");

    chk_brev_write_only: assert property (
        ea_reg.bitrev |-> $past(req_i.write) && $past(req_i.x_unit)
            && !$past(req_i.byte_size))
        else $error("reversal outside x word writes");

    chk_brev_enable_gate: assert property (
        ea_reg.bitrev |-> $past(ctrl.bitrev_enable)
            && $past(ctrl.bitrev_pointer_select) != MBAG_STACK_SEL
            && ($past(req_i.mode) == MBAG_PRE_INC || $past(req_i.mode) == MBAG_POST_INC))
        else $error("reversal without all enables");

    chk_brev_pivot_add: assert property (
        s_brev_req ##0 (w == 16'h0000) |=>
            ptr_reg[$past(req_i.ptr_sel)] == $past(pivot_bytes))
        else $error("pivot not added to pointer");

    chk_brev_precedence: assert property (
        s_brev_req ##0 circ_hit |=> ea_reg.bitrev && !ea_reg.wrapped)
        else $error("circular won over reversal");

    chk_circ_wrap_start: assert property (
        s_circ_last_word |=> ea_reg.addr == $past(ctrl.start) && ea_reg.wrapped)
        else $error("wrap did not land on start");

endmodule

// ### src/mbag_wb_regs.sv
// classic wishbone slave holding the control registers
`timescale 1ns/100ps
module mbag_wb_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [17:0] status_i,
    output mbag_pkg::mbag_ctrl_s ctrl_o
);
    import mbag_pkg::*;

    logic [15:0] bitrev_reg;
    logic [15:0] circ_ctrl_reg;
    logic [15:0] circ_start_reg;
    logic [15:0] circ_end_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic req;
    logic wr_now;
    logic [15:0] wmask;
    logic [15:0] wdat;

    assign req = wb_cyc_i && wb_stb_i;
    // write lands on the edge where the master sees ack
    assign wr_now = req && ack_reg && wb_we_i;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat = wb_dat_i[15:0] & wmask;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= req && !ack_reg;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            dat_reg <= 32'h0000_0000;
        else if (req && !ack_reg)
        begin
            unique case (wb_adr_i)
                MBAG_REG_BITREV: dat_reg <= {16'h0000, bitrev_reg};
                MBAG_REG_CIRC_CTRL: dat_reg <= {16'h0000, circ_ctrl_reg};
                MBAG_REG_CIRC_START: dat_reg <= {16'h0000, circ_start_reg};
                MBAG_REG_CIRC_END: dat_reg <= {16'h0000, circ_end_reg};
                MBAG_REG_STATUS: dat_reg <= {14'h0000, status_i};
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bitrev_reg <= MBAG_BITREV_RST;
            circ_ctrl_reg <= MBAG_CIRC_CTRL_RST;
            circ_start_reg <= MBAG_CIRC_START_RST;
            circ_end_reg <= MBAG_CIRC_END_RST;
        end
        else if (wr_now)
        begin
            unique case (wb_adr_i)
                MBAG_REG_BITREV: bitrev_reg <= (bitrev_reg & ~wmask) | wdat;
                MBAG_REG_CIRC_CTRL: circ_ctrl_reg <= (circ_ctrl_reg & ~wmask) | wdat;
                MBAG_REG_CIRC_START: circ_start_reg <= (circ_start_reg & ~wmask) | wdat;
                MBAG_REG_CIRC_END: circ_end_reg <= (circ_end_reg & ~wmask) | wdat;
                default: ;
            endcase
        end
    end

    always_comb
    begin
        ctrl_o.bitrev_enable = bitrev_reg[MBAG_BITREV_ENABLE_BIT];
        ctrl_o.pivot_modifier = bitrev_reg[14:0];
        ctrl_o.circ_en = circ_ctrl_reg[MBAG_CIRC_EN_BIT];
        ctrl_o.circ_sel = circ_ctrl_reg[MBAG_CIRC_SEL_LSB +: 4];
        ctrl_o.bitrev_pointer_select = circ_ctrl_reg[MBAG_BREV_SEL_LSB +: 4];
        ctrl_o.start = circ_start_reg;
        ctrl_o.stop = circ_end_reg;
    end
endmodule

// ### tb/mbag_top_tb.sv
// self-checking bench for the address generator: register bus and request port
`timescale 1ns/100ps
module mbag_top_tb;
    import mbag_pkg::*;

    // ==========================================================
    // clock, reset and design signals
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    mbag_req_s req_i = '0;
    logic ptr_wr_en = 1'b0;
    logic [3:0] ptr_wr_idx = 4'h0;
    logic [15:0] ptr_wr_data = 16'h0;
    logic [3:0] ptr_rd_idx = 4'h0;
    logic [15:0] ptr_rd_data;
    mbag_ea_s ea_o;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [15:0] w;

    always #50 clock = ~clock;

    mbag_top u_mbag_top (
        .clock(clock),
        .rst(rst),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .req_i(req_i),
        .ptr_wr_en(ptr_wr_en),
        .ptr_wr_idx(ptr_wr_idx),
        .ptr_wr_data(ptr_wr_data),
        .ptr_rd_idx(ptr_rd_idx),
        .ptr_rd_data(ptr_rd_data),
        .ea_o(ea_o)
    );

    // ==========================================================
    // reporting
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // whole run needs under two hundred cycles; the ceiling leaves ample slack
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // expected reverse-carry addition, written apart from the design
    function automatic logic [15:0] flip(input logic [15:0] v);
        for (int i = 0; i < 16; i++)
            flip[i] = v[15 - i];
    endfunction

    function automatic logic [15:0] radd(input logic [15:0] p, input logic [14:0] piv);
        radd = flip(flip(p) + flip({piv, 1'b0})) & 16'hfffe;
    endfunction

    // ==========================================================
    // access tasks
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0, d};
        // ack is sampled at the rising edge; data is taken and the cycle released there
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1)
            num_errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wb_check(input logic [7:0] a, input logic [31:0] exp);
        wb_xfer(1'b0, a, 16'h0);
        cmp(rd, exp);
    endtask

    task automatic ld(input logic [3:0] idx, input logic [15:0] v);
        @(posedge clock);
        ptr_wr_en <= 1'b1;
        ptr_wr_idx <= idx;
        ptr_wr_data <= v;
        @(posedge clock);
        ptr_wr_en <= 1'b0;
    endtask

    // one request; wp of x leaves the wrapped flag unchecked
    task automatic req(input logic [3:0] s, input mbag_mode_e m, input logic b, input logic wr,
                       input logic x, input logic [15:0] off, input logic [15:0] ea,
                       input logic [15:0] ptr, input logic br, input logic wp, input logic up);
        @(posedge clock);
        req_i <= '{1'b1, s, m, b, wr, x, off};
        ptr_rd_idx <= s;
        @(posedge clock);
        req_i.valid <= 1'b0;
        #1;
        cmp({31'h0, ea_o.valid}, 32'h1);
        cmp({14'h0, ea_o.bitrev, ea_o.updated, ea_o.addr}, {14'h0, br, up, ea});
        cmp({16'h0, ptr_rd_data}, {16'h0, ptr});
        if (wp !== 1'bx)
            cmp({31'h0, ea_o.wrapped}, {31'h0, wp});
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        wb_check(MBAG_REG_BITREV, 32'h0);
        wb_check(MBAG_REG_CIRC_CTRL, {16'h0, MBAG_CIRC_CTRL_RST});
        wb_check(MBAG_REG_CIRC_START, {16'h0, MBAG_CIRC_START_RST});
        wb_check(MBAG_REG_CIRC_END, {16'h0, MBAG_CIRC_END_RST});
        wb_xfer(1'b1, 8'h20, 16'h5a5a);
        wb_check(8'h20, 32'h0);
        wb_xfer(1'b1, MBAG_REG_BITREV, 16'hffff);
        wb_check(MBAG_REG_BITREV, 32'h0000ffff);

        // circular buffer 0x1000..0x100f on pointer 1, then on pointers 0, 7 and 14
        wb_xfer(1'b1, MBAG_REG_BITREV, 16'h0000);
        wb_xfer(1'b1, MBAG_REG_CIRC_START, 16'h1000);
        wb_xfer(1'b1, MBAG_REG_CIRC_END, 16'h100f);
        wb_xfer(1'b1, MBAG_REG_CIRC_CTRL, 16'h8f01);
        ld(4'h1, 16'h100e);
        req(4'h1, MBAG_PRE_INC, 0, 0, 1, 16'h0, 16'h1000, 16'h1000, 0, 1, 1);
        ld(4'h1, 16'h100e);
        req(4'h1, MBAG_POST_INC, 0, 0, 1, 16'h0, 16'h100e, 16'h1000, 0, 1, 1);
        req(4'h1, MBAG_REG_OFFSET, 0, 0, 1, 16'h0014, 16'h1004, 16'h1000, 0, 1, 0);
        req(4'h1, MBAG_PRE_DEC, 0, 0, 1, 16'h0, 16'h100e, 16'h100e, 0, 1, 1);
        req(4'h1, MBAG_POST_DEC, 1, 0, 1, 16'h0, 16'h100e, 16'h100d, 0, 0, 1);
        req(4'h1, MBAG_INDIRECT, 0, 0, 1, 16'h0, 16'h100d, 16'h100d, 0, 0, 0);
        ld(4'h2, 16'h100e);
        req(4'h2, MBAG_PRE_INC, 0, 0, 1, 16'h0, 16'h1010, 16'h1010, 0, 0, 1);
        for (int s = 0; s < 15; s += 7)
        begin
            wb_xfer(1'b1, MBAG_REG_CIRC_CTRL, {12'h8f0, 4'(s)});
            ld(4'(s), 16'h100e);
            req(4'(s), MBAG_PRE_INC, 0, 1, 1, 16'h0, 16'h1000, 16'h1000, 0, 1, 1);
        end

        // reversed addressing on pointer 3, pivot 8 words
        wb_xfer(1'b1, MBAG_REG_CIRC_CTRL, 16'h0300);
        wb_xfer(1'b1, MBAG_REG_BITREV, 16'h8008);
        w = 16'h2000;
        ld(4'h3, w);
        for (int i = 0; i < 5; i++)
        begin
            req(4'h3, MBAG_POST_INC, 0, 1, 1, 16'h0, w, radd(w, 15'h8), 1, 0, 1);
            w = radd(w, 15'h8);
        end
        req(4'h3, MBAG_PRE_INC, 0, 1, 1, 16'h0, radd(w, 15'h8), radd(w, 15'h8), 1, 0, 1);
        ld(4'h3, 16'h2001);
        req(4'h3, MBAG_POST_INC, 0, 1, 1, 16'h0, 16'h2000, 16'h2010, 1, 0, 1);
        wb_check(MBAG_REG_STATUS, 32'h00012000);
        ld(4'h3, 16'h0000);
        req(4'h3, MBAG_POST_INC, 0, 1, 1, 16'h0, 16'h0000, 16'h0010, 1, 0, 1);
        ld(4'h3, 16'h2000);
        req(4'h3, MBAG_POST_INC, 1, 1, 1, 16'h0, 16'h2000, 16'h2001, 0, 0, 1);
        req(4'h3, MBAG_PRE_DEC, 1, 1, 1, 16'h0, 16'h2000, 16'h2000, 0, 0, 1);
        req(4'h3, MBAG_POST_INC, 0, 0, 1, 16'h0, 16'h2000, 16'h2002, 0, 0, 1);
        req(4'h3, MBAG_POST_INC, 0, 1, 0, 16'h0, 16'h2002, 16'h2004, 0, 0, 1);
        req(4'h3, MBAG_POST_DEC, 0, 1, 1, 16'h0, 16'h2004, 16'h2002, 0, 0, 1);
        req(4'h3, MBAG_REG_OFFSET, 0, 1, 1, 16'h0010, 16'h2012, 16'h2002, 0, 0, 0);
        wb_xfer(1'b1, MBAG_REG_BITREV, 16'h0008);
        req(4'h3, MBAG_POST_INC, 0, 1, 1, 16'h0, 16'h2002, 16'h2004, 0, 0, 1);
        wb_xfer(1'b1, MBAG_REG_BITREV, 16'h8008);
        wb_xfer(1'b1, MBAG_REG_CIRC_CTRL, 16'h0f00);
        ld(4'hf, 16'h2000);
        req(4'hf, MBAG_POST_INC, 0, 1, 1, 16'h0, 16'h2000, 16'h2002, 0, 0, 1);

        // both modes on pointer 3: reversal wins for writes, circular still for reads
        wb_xfer(1'b1, MBAG_REG_CIRC_START, 16'h2000);
        wb_xfer(1'b1, MBAG_REG_CIRC_END, 16'h200f);
        wb_xfer(1'b1, MBAG_REG_CIRC_CTRL, 16'h8303);
        ld(4'h3, 16'h200e);
        req(4'h3, MBAG_POST_INC, 0, 1, 1, 16'h0, 16'h200e, 16'h201e, 1, 0, 1);
        ld(4'h3, 16'h200e);
        req(4'h3, MBAG_PRE_INC, 0, 0, 1, 16'h0, 16'h2000, 16'h2000, 0, 1, 1);
        tally_and_finish();
    end
endmodule
